/* dv/testbench.sv */
`timescale 1ns/100ps
module testbench;
    import uvcr_pkg::*;
    logic clk = 0;
    logic sys_rst = 1;
    logic clkEn = 1;
    uvcr_req_t req;
    uvcr_res_sel_t resSel = '0;
    logic [MV_W-1:0] inputVoltageMv = '0;
    logic [MON_W-1:0] monitorValue = '0;
    logic [15:0] readData, outputCurrentReadback, rd, v, e;
    logic readValid, lockout, overCurrent;
    uvcr_range_t inputRange;
    logic [10:0] g;
    logic [8:0] o;
    logic [11:0] m;
    int num_errors = 0, cmp_count = 0, cycles = 0, st;
    logic [7:0] cmds[5] = '{CMD_UVLO_RISE, CMD_UVLO_FALL, CMD_GAIN, CMD_OFFSET, CMD_OC_LIMIT};
    logic [15:0] masks[5] = '{16'h007F, 16'h007F, 16'h07FF, 16'h01FF, 16'h03FF};
    logic [15:0] rsts[5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h03FF};
    always #5 clk = ~clk;
    uvcr_regs u_uvcr_regs (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .req(req),
        .resSel(resSel),
        .inputVoltageMv(inputVoltageMv),
        .monitorValue(monitorValue),
        .readData(readData),
        .readValid(readValid),
        .lockout(lockout),
        .overCurrent(overCurrent),
        .inputRange(inputRange),
        .outputCurrentReadback(outputCurrentReadback)
    );
    uvcr_host_model u_uvcr_host_model (
        .clk(clk),
        .readData(readData),
        .req(req)
    );
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end
    function automatic logic [15:0] exp_cur(logic [11:0] mv, logic [10:0] gv, logic [8:0] ov);
        int s;
        s = (int'(mv) * int'(gv)) / 1024 + int'($signed(ov));
        return (s < 0) ? 16'h0000 : (s > 65535) ? 16'hFFFF : 16'(s);
    endfunction
    task check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task xf(input logic wr, input logic [7:0] cmd, input logic [15:0] d);
        u_uvcr_host_model.xfer(wr, cmd, d, rd);
    endtask
    task final_report;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h7918));
        repeat (5) @(posedge clk);
        sys_rst <= 0;
        foreach (cmds[i]) begin
            xf(0, cmds[i], 16'h0);
            check(rd, rsts[i]);
            v = $urandom | 16'hF000;
            xf(1, cmds[i], v);
            xf(0, cmds[i], 16'h0);
            check(rd, v & masks[i]);
        end
        xf(0, 8'h37, 16'h0);
        check(rd, 16'h0000);
        for (int k = 0; k < 6; k++) begin
            // host gain and offset choices, corners first
            g = (k == 0) ? 11'h400 : 11'($urandom);
            v = $urandom;
            o = (k == 1) ? 9'h180 : (k == 2) ? 9'h07F : {v[7], v[7:0]};
            m = (k == 1) ? 12'h000 : 12'($urandom);
            xf(1, CMD_GAIN, {5'h1F, g});
            xf(1, CMD_OFFSET, {7'h7F, o});
            @(posedge clk);
            monitorValue <= m;
            repeat (3) @(posedge clk);
            #1;
            e = exp_cur(m, g, o);
            check(outputCurrentReadback, e);
            xf(0, 8'h8C, 16'h0);
            check(rd, e);
        end
        xf(1, CMD_OFFSET, 16'h0);
        xf(1, CMD_GAIN, 16'h0400);
        @(posedge clk);
        monitorValue <= 12'h064;
        for (int k = 5; k < 8; k += 2) begin
            xf(1, CMD_OC_LIMIT, 16'(k));
            repeat (3) @(posedge clk);
            #1;
            check({15'h0, overCurrent}, {15'h0, k == 5});
        end
        xf(1, CMD_UVLO_FALL, 16'h000A);
        xf(1, CMD_UVLO_RISE, 16'h0014);
        for (int s = 0; s < 3; s++) begin
            st = 500 >> s;
            for (int j = 0; j < 5; j++) begin
                @(posedge clk);
                resSel <= uvcr_res_sel_t'({s == 2, s == 1});
                inputVoltageMv <= 16'((j == 1) ? 21 * st - 1 : (j == 2) ? 21 * st : (j == 3) ? 10 * st + 1 : 10 * st);
                repeat (3) @(posedge clk);
                #1;
                check({15'h0, lockout}, {15'h0, j < 2 || j == 4});
                check({14'h0, inputRange}, 16'(s));
            end
        end
        // write while frozen must not land
        @(posedge clk);
        clkEn <= 0;
        xf(1, CMD_UVLO_FALL, 16'h0055);
        @(posedge clk);
        clkEn <= 1;
        xf(0, CMD_UVLO_FALL, 16'h0);
        check(rd, 16'h000A);
        final_report();
    end
endmodule

/* dv/uvcr_host_model.sv */
`timescale 1ns/100ps
module uvcr_host_model
    import uvcr_pkg::*;
(
    input wire logic clk,
    input wire logic [15:0] readData,
    output uvcr_req_t req
);
    initial req = '0;
    // one word per access; idle lines show inverted leftovers
    task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [15:0] d, output logic [15:0] rd);
        @(posedge clk);
        req <= '{write: wr, read: !wr, command: cmd, data: d};
        @(posedge clk);
        req <= '{write: 1'b0, read: 1'b0, command: ~cmd, data: ~d};
        #1;
        rd = readData;
    endtask
endmodule

/* dv/uvcr_regs_monitor.sv */
`timescale 1ns/100ps
module uvcr_regs_monitor
    import uvcr_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire uvcr_req_t req,
    input wire uvcr_res_sel_t resSel,
    input wire logic [MV_W-1:0] inputVoltageMv,
    input wire logic [MON_W-1:0] monitorValue,
    input wire logic [15:0] readData,
    input wire logic readValid,
    input wire logic lockout,
    input wire logic overCurrent,
    input wire uvcr_range_t inputRange,
    input wire logic [CUR_W-1:0] outputCurrentReadback
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    rd_pulse_a: assert property (clkEn && req.read |=> readValid) else $error("read not answered");
    rd_quiet_a: assert property (clkEn && !req.read |=> !readValid) else $error("stray read valid");
    fall_upper_a: assert property (clkEn && req.read && req.command == CMD_UVLO_FALL |=> readData[15:7] == 0)
        else $error("fall level upper bits set");
    gain_upper_a: assert property (clkEn && req.read && req.command == CMD_GAIN |=> readData[15:11] == 0)
        else $error("gain upper bits set");
    off_upper_a: assert property (clkEn && req.read && req.command == CMD_OFFSET |=> readData[15:9] == 0)
        else $error("offset upper bits set");
    lim_upper_a: assert property (clkEn && req.read && req.command == CMD_OC_LIMIT |=> readData[15:10] == 0)
        else $error("limit upper bits set");
    fine_range_a: assert property (clkEn && resSel.selFine |=> inputRange == UVCR_RANGE_16V)
        else $error("fine select range wrong");
    mid_range_a: assert property (clkEn && resSel == 2'b01 |=> inputRange == UVCR_RANGE_32V)
        else $error("mid select range wrong");
    zero_lock_a: assert property (clkEn && inputVoltageMv == 0 |=> lockout) else $error("no lockout at zero");
    zero_oc_a: assert property (clkEn && outputCurrentReadback == 0 |=> !overCurrent)
        else $error("overcurrent at zero current");
endmodule
bind uvcr_regs uvcr_regs_monitor u_uvcr_regs_monitor (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .req(req),
    .resSel(resSel),
    .inputVoltageMv(inputVoltageMv),
    .monitorValue(monitorValue),
    .readData(readData),
    .readValid(readValid),
    .lockout(lockout),
    .overCurrent(overCurrent),
    .inputRange(inputRange),
    .outputCurrentReadback(outputCurrentReadback)
);

/* include/uvcr_pkg.sv */
package uvcr_pkg;

    // ------------------------------------------------------------
    // command codes of the register bank
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_UVLO_RISE = 8'h35;
    localparam logic [7:0] CMD_UVLO_FALL = 8'h36;
    localparam logic [7:0] CMD_GAIN = 8'h38;
    localparam logic [7:0] CMD_OFFSET = 8'h39;
    localparam logic [7:0] CMD_OC_LIMIT = 8'h46;
    localparam logic [7:0] CMD_CUR_READ = 8'h8C;

    // ------------------------------------------------------------
    // field widths
    // ------------------------------------------------------------
    localparam int UVLO_W = 7;
    localparam int GAIN_W = 11;
    localparam int OFFSET_W = 9;
    localparam int OC_W = 10;
    localparam int MON_W = 12;
    localparam int CUR_W = 16;
    localparam int MV_W = 16;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [UVLO_W-1:0] UVLO_RISE_RST = 7'h00;
    localparam logic [UVLO_W-1:0] UVLO_FALL_RST = 7'h00;
    localparam logic [GAIN_W-1:0] GAIN_RST = 11'h000;
    localparam logic [OFFSET_W-1:0] OFFSET_RST = 9'h000;
    localparam logic [OC_W-1:0] OC_RST = 10'h3FF;

    // ------------------------------------------------------------
    // resolution steps in millivolts per count
    // ------------------------------------------------------------
    localparam logic [9:0] STEP_COARSE_MV = 10'h1F4;
    localparam logic [9:0] STEP_MID_MV = 10'h0FA;
    localparam logic [9:0] STEP_FINE_MV = 10'h07D;
    // gain fraction bits and offset fraction bits (1/16 A per count)
    localparam int GAIN_FRAC = 10;
    localparam int OFFSET_FRAC = 4;

    typedef enum logic [1:0] {
        UVCR_RANGE_64V,
        UVCR_RANGE_32V,
        UVCR_RANGE_16V
    } uvcr_range_t;

    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] command;
        logic [15:0] data;
    } uvcr_req_t;

    typedef struct packed {
        logic selFine;
        logic selMid;
    } uvcr_res_sel_t;

endpackage

/* rtl/uvcr_current_calc.sv */
`timescale 1ns/100ps
module uvcr_current_calc
    import uvcr_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic [MON_W-1:0] monitorValue,
    input wire logic [GAIN_W-1:0] gain,
    input wire logic [OFFSET_W-1:0] offset,
    output logic [CUR_W-1:0] current
);
    logic [MON_W+GAIN_W-1:0] product;
    logic signed [CUR_W+2:0] sum;
    logic [CUR_W-1:0] next_current;

    always_comb begin
        product = monitorValue * gain;
        // offset is 1/16 A, result kept in the same 1/16 A units
        // whole product above the gain fraction, zero-extended to the sum width
        sum = $signed({6'h00, product[MON_W+GAIN_W-1:GAIN_FRAC]})
            + $signed({{(CUR_W+3-OFFSET_W){offset[OFFSET_W-1]}}, offset});
        if (sum < 0) begin
            next_current = '0;
        end else if (sum[CUR_W+2:CUR_W] != 3'h0) begin
            next_current = '1;
        end else begin
            next_current = sum[CUR_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            current <= '0;
        end else if (clkEn) begin
            current <= next_current;
        end
    end
endmodule

/* rtl/uvcr_regs.sv */
`timescale 1ns/100ps
module uvcr_regs
    import uvcr_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire uvcr_req_t req,
    input wire uvcr_res_sel_t resSel,
    input wire logic [MV_W-1:0] inputVoltageMv,
    input wire logic [MON_W-1:0] monitorValue,
    output logic [15:0] readData,
    output logic readValid,
    output logic lockout,
    output logic overCurrent,
    output uvcr_range_t inputRange,
    output logic [CUR_W-1:0] outputCurrentReadback
);
    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [UVLO_W-1:0] uvloRiseLevel, next_uvloRiseLevel;
    logic [UVLO_W-1:0] uvloFallLevel, next_uvloFallLevel;
    logic [GAIN_W-1:0] currentReportGain, next_currentReportGain;
    logic [OFFSET_W-1:0] currentReportOffset, next_currentReportOffset;
    logic [OC_W-1:0] overcurrentTripLimit, next_overcurrentTripLimit;
    logic [15:0] next_readData;
    logic next_readValid;
    logic next_lockout;
    logic next_overCurrent;
    logic [9:0] stepMv;
    logic [MV_W+1:0] fallMv, riseMv;
    uvcr_range_t next_inputRange;

    function automatic logic [MV_W+1:0] levelToMv(input logic [7:0] level, input logic [9:0] step);
        levelToMv = (MV_W+2)'(level * step);
    endfunction

    // ------------------------------------------------------------
    // write and read decode
    // ------------------------------------------------------------
    always_comb begin
        next_uvloRiseLevel = uvloRiseLevel;
        next_uvloFallLevel = uvloFallLevel;
        next_currentReportGain = currentReportGain;
        next_currentReportOffset = currentReportOffset;
        next_overcurrentTripLimit = overcurrentTripLimit;
        next_readData = 16'h0000;
        next_readValid = req.read;
        if (req.write) begin
            case (req.command)
                CMD_UVLO_RISE: next_uvloRiseLevel = req.data[UVLO_W-1:0];
                CMD_UVLO_FALL: next_uvloFallLevel = req.data[UVLO_W-1:0];
                CMD_GAIN: next_currentReportGain = req.data[GAIN_W-1:0];
                CMD_OFFSET: next_currentReportOffset = req.data[OFFSET_W-1:0];
                CMD_OC_LIMIT: next_overcurrentTripLimit = req.data[OC_W-1:0];
                default: ;
            endcase
        end
        if (req.read) begin
            case (req.command)
                CMD_UVLO_RISE: next_readData = {9'h000, uvloRiseLevel};
                CMD_UVLO_FALL: next_readData = {9'h000, uvloFallLevel};
                CMD_GAIN: next_readData = {5'h00, currentReportGain};
                CMD_OFFSET: next_readData = {7'h00, currentReportOffset};
                CMD_OC_LIMIT: next_readData = {6'h00, overcurrentTripLimit};
                CMD_CUR_READ: next_readData = outputCurrentReadback;
                default: next_readData = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            uvloRiseLevel <= UVLO_RISE_RST;
            uvloFallLevel <= UVLO_FALL_RST;
            currentReportGain <= GAIN_RST;
            currentReportOffset <= OFFSET_RST;
            overcurrentTripLimit <= OC_RST;
            readData <= 16'h0000;
            readValid <= 1'b0;
        end else if (clkEn) begin
            uvloRiseLevel <= next_uvloRiseLevel;
            uvloFallLevel <= next_uvloFallLevel;
            currentReportGain <= next_currentReportGain;
            currentReportOffset <= next_currentReportOffset;
            overcurrentTripLimit <= next_overcurrentTripLimit;
            readData <= next_readData;
            readValid <= next_readValid;
        end
    end

    // ------------------------------------------------------------
    // lockout and over-current compare
    // ------------------------------------------------------------
    always_comb begin
        if (resSel.selFine) begin
            stepMv = STEP_FINE_MV;
            next_inputRange = UVCR_RANGE_16V;
        end else if (resSel.selMid) begin
            stepMv = STEP_MID_MV;
            next_inputRange = UVCR_RANGE_32V;
        end else begin
            stepMv = STEP_COARSE_MV;
            next_inputRange = UVCR_RANGE_64V;
        end
        fallMv = levelToMv({1'b0, uvloFallLevel}, stepMv);
        riseMv = levelToMv(8'({1'b0, uvloRiseLevel} + 8'h01), stepMv);
        next_lockout = lockout;
        if (!lockout && ({2'b00, inputVoltageMv} <= fallMv)) begin
            next_lockout = 1'b1;
        end else if (lockout && ({2'b00, inputVoltageMv} >= riseMv)) begin
            next_lockout = 1'b0;
        end
        // readback is 1/16 A; compare limit in whole amperes
        next_overCurrent = (outputCurrentReadback[CUR_W-1:OFFSET_FRAC] > {2'b00, overcurrentTripLimit});
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lockout <= 1'b1;
            overCurrent <= 1'b0;
            inputRange <= UVCR_RANGE_64V;
        end else if (clkEn) begin
            lockout <= next_lockout;
            overCurrent <= next_overCurrent;
            inputRange <= next_inputRange;
        end
    end

    // ------------------------------------------------------------
    // output current calculation
    // ------------------------------------------------------------
    uvcr_current_calc calc (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .monitorValue(monitorValue),
        .gain(currentReportGain),
        .offset(currentReportOffset),
        .current(outputCurrentReadback)
    );
endmodule
